// ---- rtl/hdw_pkg.sv ----
// Purpose: Shared types and constants of the HS I2C DAC write slave
// Assumes: One system clock, one link sampling clock
// Notes:   Register map is reached over AXI4-Lite
// Contract
// - Master code 0000_1xxx is never acknowledged by this slave.
// - After repeated start, address 10011 plus pin bits, write, is acknowledged.
// - First data byte holds sample bits 9..2, acknowledged.
// - Second data byte holds bits 1..0 on top, rest ignored, acknowledged.
// - Power-down low byte is acknowledged; stop or repeated start follows.
// - Data word pairs keep coming until stop or repeated start.
// - Control byte bit 0 picks data words or two power-down bytes.
// - Per channel a 12-bit temporary and DAC register, power-down on top.
package hdw_pkg;
    localparam logic [4:0] ADDR_PREFIX    = 5'h13;
    localparam logic [4:0] HS_CODE_TOP    = 5'h01;
    localparam int         KIND_BIT       = 0;
    localparam int         CHAN_LSB       = 1;
    localparam int         LOAD_LSB       = 4;
    localparam logic [1:0] LOAD_TEMP_ONLY = 2'h0;
    localparam logic [1:0] LOAD_SELECTED  = 2'h1;
    localparam logic [7:0] OFS_CONFIG     = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [3:0] OFS_TEMP_PAGE  = 4'h1;
    localparam logic [3:0] OFS_DAC_PAGE   = 4'h2;
    localparam logic [1:0] CONFIG_RESET   = 2'h0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        LK_IDLE, LK_RX, LK_ACK_WAIT, LK_ACK_DRIVE, LK_IGNORE
    } hdw_link_state_e;

    typedef enum logic [2:0] {
        BK_ADDR, BK_CTRL, BK_HIGH, BK_LOW, BK_PD_HIGH, BK_PD_LOW, BK_DONE
    } hdw_byte_kind_e;

    typedef struct packed {
        logic [1:0]  chan;
        logic [1:0]  load;
        logic        pd;
        logic [11:0] value;
    } hdw_word_s;

    typedef struct packed {
        logic            scl_s1;
        logic            scl_s2;
        logic            scl_s3;
        logic            sda_s1;
        logic            sda_s2;
        logic            sda_s3;
        logic [1:0]      cfg_s1;
        logic [1:0]      cfg_s2;
        hdw_link_state_e state;
        hdw_byte_kind_e  kind;
        logic [7:0]      shift;
        logic [3:0]      bitcnt;
        logic [7:0]      ctrl;
        logic [7:0]      high;
        logic            hs_mode;
        logic            sel;
        logic            sda_out;
        logic            sda_oe;
        hdw_word_s       word;
        logic            word_tgl;
    } hdw_link_s;

    typedef struct packed {
        logic             tgl_s1;
        logic             tgl_s2;
        logic             tgl_s3;
        logic             hs_s1;
        logic             hs_s2;
        logic             adr_s1;
        logic             adr_s2;
        logic [1:0]       cfg;
        logic [3:0][11:0] temp;
        logic [3:0][11:0] dac;
        logic [7:0]       words;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [7:0]       wdata;
        logic             wstrb0;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } hdw_sys_s;
endpackage : hdw_pkg

// ---- rtl/hdw_dac_slave.sv ----
// Purpose: HS I2C write slave of a quad 10-bit DAC with AXI4-Lite view
// Assumes: link_clk oversamples SCL and SDA at least four times per bit
// Notes:   Decoded words cross to clock by a toggle with held payload
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module hdw_dac_slave (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              link_clk,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [3:0][11:0]       dac_code
);
    hdw_pkg::hdw_link_s lk_reg;
    hdw_pkg::hdw_link_s lk_next;
    hdw_pkg::hdw_sys_s  sy_reg;
    hdw_pkg::hdw_sys_s  sy_next;
    logic               rst_l1;
    logic               rst_l2;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_ev;
    logic               stop_ev;
    logic               byte_done;
    logic [7:0]         rx_byte;
    logic               new_word;

    // ****************************************
    // Link domain
    // ****************************************
    // Reset is brought over as a level; hold rst across at least one link edge
    always_ff @(posedge link_clk) begin
        rst_l1 <= rst;
        rst_l2 <= rst_l1;
    end

    assign scl_rise  = lk_reg.scl_s2 & ~lk_reg.scl_s3;
    assign scl_fall  = ~lk_reg.scl_s2 & lk_reg.scl_s3;
    assign start_ev  = lk_reg.scl_s2 & lk_reg.scl_s3 & ~lk_reg.sda_s2 & lk_reg.sda_s3;
    assign stop_ev   = lk_reg.scl_s2 & lk_reg.scl_s3 & lk_reg.sda_s2 & ~lk_reg.sda_s3;
    assign rx_byte   = {lk_reg.shift[6:0], lk_reg.sda_s2};
    assign byte_done = (lk_reg.state == hdw_pkg::LK_RX) && scl_rise
                       && (lk_reg.bitcnt == 4'h7);

    always_comb begin
        lk_next = lk_reg;
        lk_next.scl_s1 = scl_in;
        lk_next.scl_s2 = lk_reg.scl_s1;
        lk_next.scl_s3 = lk_reg.scl_s2;
        lk_next.sda_s1 = sda_in;
        lk_next.sda_s2 = lk_reg.sda_s1;
        lk_next.sda_s3 = lk_reg.sda_s2;
        // Address pins are quasi-static; change them only while idle
        lk_next.cfg_s1 = sy_reg.cfg;
        lk_next.cfg_s2 = lk_reg.cfg_s1;
        lk_next.sda_out = 1'b0;
        unique case (lk_reg.state)
            hdw_pkg::LK_IDLE, hdw_pkg::LK_IGNORE: begin
            end
            hdw_pkg::LK_RX: begin
                if (scl_rise) begin
                    lk_next.shift  = rx_byte;
                    lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
                end
                if (byte_done) begin
                    lk_next.state = hdw_pkg::LK_ACK_WAIT;
                    unique case (lk_reg.kind)
                        hdw_pkg::BK_ADDR: begin
                            if (rx_byte[7:3] == hdw_pkg::HS_CODE_TOP) begin
                                lk_next.state   = hdw_pkg::LK_IGNORE;
                                lk_next.hs_mode = 1'b1;
                            end else if (rx_byte[7:1] == {hdw_pkg::ADDR_PREFIX,
                                         lk_reg.cfg_s2} && !rx_byte[0]) begin
                                lk_next.kind = hdw_pkg::BK_CTRL;
                                lk_next.sel  = 1'b1;
                            end else begin
                                lk_next.state = hdw_pkg::LK_IGNORE;
                            end
                        end
                        hdw_pkg::BK_CTRL: begin
                            lk_next.ctrl = rx_byte;
                            lk_next.kind = rx_byte[hdw_pkg::KIND_BIT] ?
                                           hdw_pkg::BK_PD_HIGH : hdw_pkg::BK_HIGH;
                        end
                        hdw_pkg::BK_HIGH: begin
                            lk_next.high = rx_byte;
                            lk_next.kind = hdw_pkg::BK_LOW;
                        end
                        hdw_pkg::BK_LOW: begin
                            lk_next.word.chan  = lk_reg.ctrl[hdw_pkg::CHAN_LSB +: 2];
                            lk_next.word.load  = lk_reg.ctrl[hdw_pkg::LOAD_LSB +: 2];
                            lk_next.word.pd    = 1'b0;
                            lk_next.word.value = {2'h0, lk_reg.high, rx_byte[7:6]};
                            lk_next.word_tgl   = ~lk_reg.word_tgl;
                            lk_next.kind = hdw_pkg::BK_HIGH;
                        end
                        hdw_pkg::BK_PD_HIGH: begin
                            lk_next.high = rx_byte;
                            lk_next.kind = hdw_pkg::BK_PD_LOW;
                        end
                        hdw_pkg::BK_PD_LOW: begin
                            lk_next.word.chan  = lk_reg.ctrl[hdw_pkg::CHAN_LSB +: 2];
                            lk_next.word.load  = lk_reg.ctrl[hdw_pkg::LOAD_LSB +: 2];
                            lk_next.word.pd    = 1'b1;
                            lk_next.word.value = {lk_reg.high[7:6], 10'h000};
                            lk_next.word_tgl   = ~lk_reg.word_tgl;
                            lk_next.kind       = hdw_pkg::BK_DONE;
                        end
                        hdw_pkg::BK_DONE: begin
                            // Extra bytes after power-down are not taken
                            lk_next.state = hdw_pkg::LK_IGNORE;
                        end
                        default: begin
                            lk_next.state = hdw_pkg::LK_IGNORE;
                        end
                    endcase
                end
            end
            hdw_pkg::LK_ACK_WAIT: begin
                if (scl_fall) begin
                    lk_next.sda_oe = 1'b1;
                    lk_next.state  = hdw_pkg::LK_ACK_DRIVE;
                end
            end
            hdw_pkg::LK_ACK_DRIVE: begin
                if (scl_fall) begin
                    lk_next.sda_oe = 1'b0;
                    lk_next.bitcnt = 4'h0;
                    lk_next.state  = hdw_pkg::LK_RX;
                end
            end
            default: begin
                lk_next.state = hdw_pkg::LK_IDLE;
            end
        endcase
        // only start or stop ends the stream
        if (start_ev) begin
            lk_next.state  = hdw_pkg::LK_RX;
            lk_next.kind   = hdw_pkg::BK_ADDR;
            lk_next.bitcnt = 4'h0;
            lk_next.sda_oe = 1'b0;
            lk_next.sel    = 1'b0;
        end else if (stop_ev) begin
            lk_next.state   = hdw_pkg::LK_IDLE;
            lk_next.hs_mode = 1'b0;
            lk_next.sel     = 1'b0;
            lk_next.sda_oe  = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_l2) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    assign sda_out = lk_reg.sda_out;
    assign sda_oe  = lk_reg.sda_oe;

    // ****************************************
    // System domain
    // ****************************************
    assign new_word = sy_reg.tgl_s2 ^ sy_reg.tgl_s3;

    always_comb begin
        hdw_pkg::hdw_word_s w;
        logic [11:0]        nv;
        w  = lk_reg.word;
        nv = sy_reg.temp[w.chan];
        sy_next = sy_reg;
        sy_next.tgl_s1 = lk_reg.word_tgl;
        sy_next.tgl_s2 = sy_reg.tgl_s1;
        sy_next.tgl_s3 = sy_reg.tgl_s2;
        sy_next.hs_s1  = lk_reg.hs_mode;
        sy_next.hs_s2  = sy_reg.hs_s1;
        sy_next.adr_s1 = lk_reg.sel;
        sy_next.adr_s2 = sy_reg.adr_s1;
        // Payload is held by the link side until the next byte pair ends
        if (new_word) begin
            if (w.pd) begin
                nv[11:10] = w.value[11:10];
            end else begin
                nv[9:0] = w.value[9:0];
            end
            sy_next.temp[w.chan] = nv;
            for (int i = 0; i < 4; i++) begin
                if ((w.load == hdw_pkg::LOAD_SELECTED) ? (w.chan == 2'(i))
                    : (w.load != hdw_pkg::LOAD_TEMP_ONLY)) begin
                    sy_next.dac[i] = sy_next.temp[i];
                end
            end
            sy_next.words = sy_reg.words + 8'h01;
        end
        // Write channel pair, either order
        if (s_axi_awvalid && sy_reg.awready) begin
            sy_next.aw_got = 1'b1;
            sy_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && sy_reg.wready) begin
            sy_next.w_got  = 1'b1;
            sy_next.wdata  = s_axi_wdata[7:0];
            sy_next.wstrb0 = s_axi_wstrb[0];
        end
        if (sy_reg.bvalid && s_axi_bready) begin
            sy_next.bvalid = 1'b0;
        end
        if (sy_next.aw_got && sy_next.w_got && !sy_next.bvalid) begin
            sy_next.aw_got = 1'b0;
            sy_next.w_got  = 1'b0;
            sy_next.bvalid = 1'b1;
            sy_next.bresp  = hdw_pkg::RESP_SLVERR;
            if (sy_next.awaddr == hdw_pkg::OFS_CONFIG) begin
                sy_next.bresp = hdw_pkg::RESP_OKAY;
                if (sy_next.wstrb0) begin
                    sy_next.cfg = sy_next.wdata[1:0];
                end
            end
        end
        sy_next.awready = !sy_next.aw_got && !sy_next.bvalid;
        sy_next.wready  = !sy_next.w_got && !sy_next.bvalid;
        // Read channel
        if (sy_reg.rvalid && s_axi_rready) begin
            sy_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && sy_reg.arready) begin
            sy_next.rvalid = 1'b1;
            sy_next.rresp  = hdw_pkg::RESP_OKAY;
            sy_next.rdata  = 32'h0;
            if (s_axi_araddr == hdw_pkg::OFS_CONFIG) begin
                sy_next.rdata[1:0] = sy_reg.cfg;
            end else if (s_axi_araddr == hdw_pkg::OFS_STATUS) begin
                sy_next.rdata[15:0] = {sy_reg.words, 6'h00, sy_reg.adr_s2, sy_reg.hs_s2};
            end else if (s_axi_araddr[7:4] == hdw_pkg::OFS_TEMP_PAGE) begin
                sy_next.rdata[11:0] = sy_reg.temp[s_axi_araddr[3:2]];
            end else if (s_axi_araddr[7:4] == hdw_pkg::OFS_DAC_PAGE) begin
                sy_next.rdata[11:0] = sy_reg.dac[s_axi_araddr[3:2]];
            end else begin
                sy_next.rresp = hdw_pkg::RESP_SLVERR;
            end
        end
        sy_next.arready = !sy_next.rvalid;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sy_reg     <= '0;
            sy_reg.cfg <= hdw_pkg::CONFIG_RESET;
        end else begin
            sy_reg <= sy_next;
        end
    end

    assign s_axi_awready = sy_reg.awready;
    assign s_axi_wready  = sy_reg.wready;
    assign s_axi_bvalid  = sy_reg.bvalid;
    assign s_axi_bresp   = sy_reg.bresp;
    assign s_axi_arready = sy_reg.arready;
    assign s_axi_rvalid  = sy_reg.rvalid;
    assign s_axi_rdata   = sy_reg.rdata;
    assign s_axi_rresp   = sy_reg.rresp;
    assign dac_code      = sy_reg.dac;

    // ****************************************
    // Assertions
    // ****************************************
    property p_mc_nack;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_ADDR && rx_byte[7:3] == 5'h01
        |=> lk_reg.state == hdw_pkg::LK_IGNORE && lk_reg.hs_mode && !lk_reg.sda_oe;
    endproperty
    a_mc_nack: assert property (p_mc_nack) else $error("Master code answered");
    property p_addr_ack;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_ADDR && rx_byte == {5'h13, lk_reg.cfg_s2, 1'b0}
        |=> lk_reg.state == hdw_pkg::LK_ACK_WAIT && lk_reg.kind == hdw_pkg::BK_CTRL;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Address not taken");
    property p_ack_hold;
        @(posedge link_clk) disable iff (rst_l2)
        lk_reg.state == hdw_pkg::LK_ACK_DRIVE && !scl_fall && !start_ev && !stop_ev
        |=> lk_reg.sda_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("Ack dropped early");
    property p_high_byte;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_HIGH && !start_ev && !stop_ev
        |=> lk_reg.high == $past(rx_byte) && lk_reg.state == hdw_pkg::LK_ACK_WAIT;
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("High byte lost");
    property p_low_word;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_LOW
        |=> lk_reg.word_tgl != $past(lk_reg.word_tgl)
            && lk_reg.word.value[9:0] == {$past(lk_reg.high), $past(rx_byte[7:6])};
    endproperty
    a_low_word: assert property (p_low_word) else $error("Data word wrong");
    property p_pd_low;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_PD_LOW && !start_ev && !stop_ev
        |=> lk_reg.kind == hdw_pkg::BK_DONE ##1 lk_reg.state == hdw_pkg::LK_ACK_WAIT [*1];
    endproperty
    a_pd_low: assert property (p_pd_low) else $error("Power-down end wrong");
    property p_stream;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_LOW && !start_ev && !stop_ev
        |=> lk_reg.kind == hdw_pkg::BK_HIGH;
    endproperty
    a_stream: assert property (p_stream) else $error("Stream not repeating");
    property p_stop;
        @(posedge link_clk) disable iff (rst_l2)
        stop_ev && !start_ev |=> lk_reg.state == hdw_pkg::LK_IDLE && !lk_reg.sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("Stop not honoured");
    property p_kind_sel;
        @(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_CTRL && !start_ev && !stop_ev
        |=> lk_reg.kind == (lk_reg.ctrl[0] ? hdw_pkg::BK_PD_HIGH : hdw_pkg::BK_HIGH)
            && lk_reg.ctrl == $past(rx_byte);
    endproperty
    a_kind_sel: assert property (p_kind_sel) else $error("Control byte misread");
    property p_temp;
        @(posedge clock) disable iff (rst)
        new_word && !lk_reg.word.pd
        |=> sy_reg.temp[$past(lk_reg.word.chan)][9:0] == $past(lk_reg.word.value[9:0]);
    endproperty
    a_temp: assert property (p_temp) else $error("Temporary not written");
    property p_rd_answer;
        @(posedge clock) disable iff (rst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("Read not answered");
    c_mc: cover property (@(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_ADDR && rx_byte[7:3] == 5'h01);
    c_pd: cover property (@(posedge link_clk) disable iff (rst_l2)
        byte_done && lk_reg.kind == hdw_pkg::BK_PD_LOW);
    c_two: cover property (@(posedge clock) disable iff (rst) sy_reg.words == 8'h02);
    c_rd: cover property (@(posedge clock) disable iff (rst)
        s_axi_rvalid && s_axi_rready);
endmodule : hdw_dac_slave

// ---- dv/hdw_i2c_master.sv ----
// Purpose: Behavioural I2C bus master for the DAC write slave
// Assumes: SDA has a pull-up, so a released line reads high
// Notes:   SCL stands high between frames
`timescale 1ns/1ns
module hdw_i2c_master (
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda_line
);
    // Wide half bit so the slave's synchronised ack lands well inside SCL low
    localparam int HALF = 1600;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic start;
        sda_rel = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_rel = 1'b0;
        #HALF scl = 1'b0;
    endtask : start
    task automatic stop;
        #(HALF/2) sda_rel = 1'b0;
        #(HALF/2) scl = 1'b1;
        #HALF sda_rel = 1'b1;
        #HALF;
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(HALF/2) sda_rel = b[i];
            #(HALF/2) scl = 1'b1;
            #HALF scl = 1'b0;
        end
        #(HALF/2) sda_rel = 1'b1;
        #(HALF/2) scl = 1'b1;
        #(HALF/2) ack = ~sda_line;
        #(HALF/2) scl = 1'b0;
    endtask : send_byte
endmodule : hdw_i2c_master

// ---- dv/test_hdw_dac_slave.sv ----
// Purpose: Self-checking bench of the HS I2C DAC write slave
// Assumes: The master model drives SCL and SDA, the bench drives AXI4-Lite
// Notes:   Link clock runs free, unrelated in phase to the system clock
`timescale 1ns/1ns
module test_hdw_dac_slave;
    logic             clock = 1'b0;
    logic             rst = 1'b1;
    logic             link_clk = 1'b0;
    logic             scl, sda_rel, sda_out, sda_oe, awready, wready, bvalid, arready, rvalid;
    logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic             rready = 1'b0;
    logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]      wdata = 32'h0, rdata, rd;
    logic [1:0]       bresp, rresp, resp;
    logic [3:0][11:0] dac_code;
    int               failures = 0, checks_done = 0;
    wire              sda_line = sda_rel & ~(sda_oe & ~sda_out);

    hdw_dac_slave hdw_dac_slave_inst (.clock(clock), .rst(rst), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dac_code(dac_code));
    hdw_i2c_master hdw_i2c_master_inst (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        hdw_i2c_master_inst.send_byte(b, ack);
        check("ack", {31'h0, ack}, {31'h0, exp_ack});
    endtask : send
    task automatic test_registers;
        check("dac reset lo", {8'h0, dac_code[1:0]}, 32'h0);
        check("dac reset hi", {8'h0, dac_code[3:2]}, 32'h0);
        axi_write(hdw_pkg::OFS_CONFIG, 32'h2);
        check("cfg resp", 32'(resp), 32'(hdw_pkg::RESP_OKAY));
        axi_read(hdw_pkg::OFS_CONFIG);
        check("cfg", rd, 32'h2);
        axi_write(8'h08, 32'h3);
        check("bad wr", 32'(resp), 32'(hdw_pkg::RESP_SLVERR));
        axi_read(8'h40);
        check("bad rd", {rd[29:0], resp}, {30'h0, hdw_pkg::RESP_SLVERR});
    endtask : test_registers
    task automatic test_data_words;
        hdw_i2c_master_inst.start();
        send(8'h08, 1'b0);
        hdw_i2c_master_inst.start();
        send({hdw_pkg::ADDR_PREFIX, 2'h2, 1'b0}, 1'b1);
        send(8'h14, 1'b1);
        send(8'ha5, 1'b1);
        send(8'h7f, 1'b1);
        check("word1", 32'(dac_code[2]), 32'h295);
        send(8'h3c, 1'b1);
        send(8'h80, 1'b1);
        check("word2", 32'(dac_code[2]), 32'h0f2);
        hdw_i2c_master_inst.start();
        send({hdw_pkg::ADDR_PREFIX, 2'h3, 1'b0}, 1'b0);
        // High-speed flag only lasts until the stop
        axi_read(hdw_pkg::OFS_STATUS);
        check("status", rd & 32'hff01, 32'h0201);
        hdw_i2c_master_inst.stop();
        axi_read(8'h18);
        check("temp2", rd, 32'h0f2);
        axi_read(hdw_pkg::OFS_STATUS);
        check("status idle", rd & 32'hff03, 32'h0200);
    endtask : test_data_words
    task automatic test_power_down;
        hdw_i2c_master_inst.start();
        send(8'h0b, 1'b0);
        hdw_i2c_master_inst.start();
        send({hdw_pkg::ADDR_PREFIX, 2'h2, 1'b0}, 1'b1);
        send(8'h13, 1'b1);
        send(8'hc0, 1'b1);
        send(8'h3f, 1'b1);
        send(8'h55, 1'b0);
        hdw_i2c_master_inst.stop();
        check("pd dac1", 32'(dac_code[1]), 32'hc00);
        check("dac0", 32'(dac_code[0]), 32'h000);
    endtask : test_power_down
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    initial begin
        // One link edge inside reset is enough for the link copy to take hold
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (40) @(posedge clock);
        test_registers();
        test_data_words();
        test_power_down();
        complete_run();
    end
    initial begin
        #1_000_000;
        failures++;
        complete_run();
    end
endmodule : test_hdw_dac_slave
